// file: design/cfg_pkg.sv
package cfg_pkg;
  localparam int       SEL_W          = 6;
  localparam int       ADDR_W         = 6;
  // Register offsets
  localparam bit [5:0] ADDR_PIN_C     = 6'h00;
  localparam bit [5:0] ADDR_PIN_B     = 6'h01;
  localparam bit [5:0] ADDR_PIN_A     = 6'h02;
  localparam bit [5:0] ADDR_THR       = 6'h03;
  localparam bit [5:0] ADDR_TRIM_TWO  = 6'h2C;
  localparam bit [5:0] ADDR_TRIM_ONE  = 6'h2D;
  localparam bit [5:0] ADDR_CFG_LAST  = 6'h2E;
  // Reset values
  localparam bit [7:0] RST_PIN_C      = 8'h29;
  localparam bit [7:0] RST_PIN_B      = 8'h2E;
  localparam bit [7:0] RST_PIN_A      = 8'h3F;
  localparam bit [7:0] RST_THR        = 8'h07;
  // Field positions
  localparam int       BIT_TOP        = 7;
  localparam int       BIT_INV        = 6;
  localparam int       BIT_KEEP       = 6;
  localparam int       ATTEN_LSB      = 4;
  localparam int       LIMIT_LSB      = 0;
  // Header byte fields
  localparam int       HDR_RW         = 7;
  localparam int       HDR_BURST      = 6;
  // Special select code for a floating pin
  localparam bit [5:0] SEL_HIZ        = 6'h2E;
  // Analog trims applied on wake, and their reset values
  localparam bit [7:0] TRIM_ONE_RST   = 8'h31;
  localparam bit [7:0] TRIM_TWO_RST   = 8'h88;
  localparam bit [7:0] TRIM_ONE_KEEP  = 8'h35;
  localparam bit [7:0] TRIM_TWO_KEEP  = 8'h81;
  // FIFO limit mapping
  localparam bit [6:0] TX_LIMIT_BASE  = 7'h3D;
  localparam bit [6:0] RX_LIMIT_STEP  = 7'h04;
  localparam int       FILL_MIN_W     = 7;
endpackage

// file: design/pin_mux.sv
`timescale 1ns/100ps
module pin_mux import cfg_pkg::*; #(
  parameter int W = SEL_W
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic [W-1:0]   sel,
  input  wire logic           invert,
  input  wire logic [2**W-1:0] sources,
  output logic                pin,
  output logic                pin_oe
);
  if (W < SEL_W) begin : g_check
    $error("W too narrow for the six-bit select codes");
  end

  wire hiz = (sel == W'(SEL_HIZ));
  always_ff @(posedge clk) begin
    if (srst) begin
      pin    <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin    <= sources[sel] ^ invert;
      pin_oe <= ~hiz;
    end
  end
endmodule

// file: design/pin_select_fifo_threshold_regs.sv
`timescale 1ns/100ps
module pin_select_fifo_threshold_regs import cfg_pkg::*; #(
  parameter int FILL_W = 7
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Serial register port
  input  wire logic              csn,
  input  wire logic              sclk,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe,
  // Power state, high while asleep
  input  wire logic              sleep,
  // Internal signals selectable onto pins
  input  wire logic [63:0]       sig_src,
  // FIFO fill levels in bytes
  input  wire logic [FILL_W-1:0] tx_fill,
  input  wire logic [FILL_W-1:0] rx_fill,
  // General output pins
  output logic                   out_pin_a,
  output logic                   out_pin_a_oe,
  output logic                   out_pin_b,
  output logic                   out_pin_b_oe,
  output logic                   out_pin_c,
  output logic                   out_pin_c_oe,
  // Analog controls
  output logic                   pins_drive_strength,
  output logic                   temp_sensor_enable,
  output logic [1:0]             rx_attenuation,
  output logic [7:0]             analog_trim_one,
  output logic [7:0]             analog_trim_two,
  output logic                   trim_load,
  // Threshold flags
  output logic                   tx_limit_reached,
  output logic                   rx_limit_reached
);
  if (FILL_W < FILL_MIN_W) begin : g_check
    $error("FILL_W too narrow for a 64-byte FIFO");
  end

  reg_access_if bus ();

  logic [7:0] pin_c_cfg;
  logic [7:0] pin_b_cfg;
  logic [7:0] pin_a_cfg;
  logic [7:0] thr_cfg;
  logic       sleep_q;
  logic       chip_ready_low;

  spi_port u_port (
    .clk     (clk),
    .srst    (srst),
    .csn     (csn),
    .sclk    (sclk),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .bus     (bus)
  );

  // Writes are dropped while asleep; nothing clears on sleep entry
  wire wr_ok   = bus.wr & ~sleep;
  wire wr_c    = wr_ok & (bus.addr == ADDR_PIN_C);
  wire wr_b    = wr_ok & (bus.addr == ADDR_PIN_B);
  wire wr_a    = wr_ok & (bus.addr == ADDR_PIN_A);
  wire wr_thr  = wr_ok & (bus.addr == ADDR_THR);

  // Top bit of pin C is unused and reads zero
  wire [7:0] rd_c = {1'b0, pin_c_cfg[BIT_INV:0]};
  assign bus.rdata  = (bus.addr == ADDR_PIN_C)    ? rd_c      :
                      (bus.addr == ADDR_PIN_B)    ? pin_b_cfg :
                      (bus.addr == ADDR_PIN_A)    ? pin_a_cfg :
                      (bus.addr == ADDR_THR)      ? thr_cfg   :
                      (bus.addr == ADDR_TRIM_ONE) ? TRIM_ONE_RST :
                      (bus.addr == ADDR_TRIM_TWO) ? TRIM_TWO_RST : 8'h00;
  assign bus.status = {chip_ready_low, 7'h00};

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_c_cfg <= RST_PIN_C;
      pin_b_cfg <= RST_PIN_B;
      pin_a_cfg <= RST_PIN_A;
      thr_cfg   <= RST_THR;
    end else begin
      if (wr_c)
        pin_c_cfg <= {1'b0, bus.wdata[BIT_INV:0]};
      if (wr_b)
        pin_b_cfg <= bus.wdata;
      if (wr_a)
        pin_a_cfg <= bus.wdata;
      if (wr_thr)
        thr_cfg <= bus.wdata;
    end
  end

  // Pin multiplexers, one per general output
  wire [2:0][5:0] pin_sel = {pin_c_cfg[5:0], pin_b_cfg[5:0], pin_a_cfg[5:0]};
  wire [2:0]      pin_inv = {pin_c_cfg[BIT_INV], pin_b_cfg[BIT_INV], pin_a_cfg[BIT_INV]};
  logic [2:0]     pin_q;
  logic [2:0]     pin_oe_q;

  for (genvar i = 0; i < 3; i++) begin : g_pin
    pin_mux #(.W(SEL_W)) u_mux (
      .clk     (clk),
      .srst    (srst),
      .sel     (pin_sel[i]),
      .invert  (pin_inv[i]),
      .sources (sig_src),
      .pin     (pin_q[i]),
      .pin_oe  (pin_oe_q[i])
    );
  end

  assign out_pin_a    = pin_q[0];
  assign out_pin_a_oe = pin_oe_q[0];
  assign out_pin_b    = pin_q[1];
  assign out_pin_b_oe = pin_oe_q[1];
  assign out_pin_c    = pin_q[2];
  assign out_pin_c_oe = pin_oe_q[2];

  // FIFO limits from the shared four-bit field
  wire [3:0] lim_n     = thr_cfg[LIMIT_LSB +: 4];
  wire [6:0] lim_x4    = {1'b0, lim_n, 2'b00};
  wire [6:0] tx_limit  = TX_LIMIT_BASE - lim_x4;
  wire [6:0] rx_limit  = lim_x4 + RX_LIMIT_STEP;
  wire       tx_reach  = tx_fill >= FILL_W'(tx_limit);
  wire       rx_reach  = rx_fill >= FILL_W'(rx_limit);

  // Trims only move on reset and on the falling edge of sleep
  wire       wake      = sleep_q & ~sleep;
  wire       keep      = thr_cfg[BIT_KEEP];
  wire [7:0] next_one  = keep ? TRIM_ONE_KEEP : TRIM_ONE_RST;
  wire [7:0] next_two  = keep ? TRIM_TWO_KEEP : TRIM_TWO_RST;

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_q             <= 1'b0;
      chip_ready_low      <= 1'b0;
      tx_limit_reached    <= 1'b0;
      rx_limit_reached    <= 1'b0;
      pins_drive_strength <= 1'b0;
      temp_sensor_enable  <= 1'b0;
      rx_attenuation      <= 2'b00;
      analog_trim_one     <= TRIM_ONE_RST;
      analog_trim_two     <= TRIM_TWO_RST;
      trim_load           <= 1'b0;
    end else begin
      sleep_q             <= sleep;
      chip_ready_low      <= sleep;
      tx_limit_reached    <= tx_reach;
      rx_limit_reached    <= rx_reach;
      pins_drive_strength <= pin_b_cfg[BIT_TOP];
      temp_sensor_enable  <= pin_a_cfg[BIT_TOP];
      rx_attenuation      <= thr_cfg[ATTEN_LSB +: 2];
      trim_load           <= wake;
      if (wake) begin
        analog_trim_one <= next_one;
        analog_trim_two <= next_two;
      end
    end
  end
endmodule

// file: design/reg_access_if.sv
`timescale 1ns/100ps
interface reg_access_if;
  logic       wr;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] status;
  modport port (output wr, addr, wdata, input rdata, status);
  modport bank (input wr, addr, wdata, output rdata, status);
endinterface

// file: design/spi_port.sv
`timescale 1ns/100ps
module spi_port import cfg_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Serial pins
  input  wire logic csn,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // Register side
  reg_access_if.port bus
);
  typedef enum logic [1:0] {ST_HDR = 2'b01, ST_DATA = 2'b10} phase_e;
  phase_e     phase;
  logic       sclk_q;
  logic [2:0] bit_cnt;
  logic [6:0] in_sh;
  logic [7:0] tx_sh;
  logic       rw;
  logic       burst;
  logic       step;
  wire        rise     = sclk & ~sclk_q & ~csn;
  wire        fall     = ~sclk & sclk_q & ~csn;
  wire        byte_end = rise & (bit_cnt == 3'h7);
  wire  [7:0] byte_in  = {in_sh, mosi};
  wire  [7:0] next_tx  = (phase == ST_DATA && rw) ? bus.rdata : bus.status;

  always_ff @(posedge clk) begin
    sclk_q  <= sclk;
    miso_oe <= ~srst & ~csn;
  end

  always_ff @(posedge clk) begin
    bus.wr <= 1'b0;
    step   <= 1'b0;
    if (srst || csn) begin
      phase   <= ST_HDR;
      bit_cnt <= 3'h0;
      rw      <= 1'b0;
      burst   <= 1'b0;
      if (srst) begin
        bus.addr  <= 6'h00;
        bus.wdata <= 8'h00;
      end
    end else if (rise) begin
      in_sh   <= byte_in[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end) begin
        unique case (phase)
          ST_HDR: begin
            rw       <= byte_in[HDR_RW];
            burst    <= byte_in[HDR_BURST];
            bus.addr <= byte_in[5:0];
            phase    <= ST_DATA;
          end
          ST_DATA: begin
            bus.wr    <= ~rw;
            bus.wdata <= byte_in;
            step      <= burst;
            if (!burst)
              phase <= ST_HDR;
          end
        endcase
      end
    end else if (step) begin
      // Step with the write pulse, so the bank still sees the old address
      bus.addr <= bus.addr + 6'h01;
    end
  end

  // Next byte is chosen at the falling edge after the eighth rising edge of the previous byte
  always_ff @(posedge clk) begin
    if (srst || csn) begin
      tx_sh <= bus.status;
      miso  <= 1'b0;
    end else if (fall) begin
      if (bit_cnt == 3'h0) begin
        tx_sh <= {next_tx[6:0], 1'b0};
        miso  <= next_tx[7];
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b0};
        miso  <= tx_sh[7];
      end
    end else if (phase == ST_HDR && bit_cnt == 3'h0) begin
      tx_sh <= {bus.status[6:0], 1'b0};
      miso  <= bus.status[7];
    end
  end
endmodule

// file: tb/regs_properties.sv
`timescale 1ns/100ps
module regs_properties #(
  parameter int FILL_W = 7
) (
  // Watched ports of the register bank
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              csn,
  input wire logic              sleep,
  input wire logic [FILL_W-1:0] tx_fill,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic              miso_oe,
  input wire logic              pins_drive_strength,
  input wire logic [1:0]        rx_attenuation,
  input wire logic [7:0]        analog_trim_one,
  input wire logic [7:0]        analog_trim_two,
  input wire logic              trim_load,
  input wire logic              tx_limit_reached,
  input wire logic              rx_limit_reached
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wake; sleep ##1 !sleep; endsequence
  // Largest limits are 61 and 64, so these fills always reach them
  property p_tx_top; tx_fill >= 61 |=> tx_limit_reached; endproperty
  a_tx_top: assert property (p_tx_top) else $error("tx flag low at full fill");
  property p_rx_top; rx_fill >= 64 |=> rx_limit_reached; endproperty
  a_rx_top: assert property (p_rx_top) else $error("rx flag low at full fill");
  property p_rx_low; rx_fill < 4 |=> !rx_limit_reached; endproperty
  a_rx_low: assert property (p_rx_low) else $error("rx flag high below limit");
  property p_oe_follow; 1'b1 |=> miso_oe == !$past(csn); endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("miso enable off select");
  property p_sleep_keep;
    sleep [*3] |-> $stable(pins_drive_strength) && $stable(rx_attenuation);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("setting moved in sleep");
  property p_trim_pair;
    (analog_trim_one == 8'h31 && analog_trim_two == 8'h88)
      || (analog_trim_one == 8'h35 && analog_trim_two == 8'h81);
  endproperty
  a_trim_pair: assert property (p_trim_pair) else $error("trim pair invalid");
  // Past reset excluded: a one-edge reset may still move the trims
  property p_trim_hold;
    !trim_load && !$past(trim_load) && !$past(srst) |-> $stable(analog_trim_one);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved off wake");
  property p_wake; s_wake |-> ##[0:1] trim_load; endproperty
  a_wake: assert property (p_wake) else $error("no trim load on wake");
endmodule

bind pin_select_fifo_threshold_regs regs_properties #(.FILL_W(FILL_W)) u_props (
  .clk, .srst, .csn, .sleep, .tx_fill, .rx_fill, .miso_oe, .pins_drive_strength,
  .rx_attenuation, .analog_trim_one, .analog_trim_two, .trim_load, .tx_limit_reached,
  .rx_limit_reached
);

// file: tb/spi_host.sv
`timescale 1ns/100ps
module spi_host (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic miso,
  output logic      csn = 1'h1,
  output logic      sclk = 1'h0,
  output logic      mosi = 1'h0
);
  // Header then one or two data bytes; each sclk phase 3 clk so the sampler sees it
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] dat, input int nbits,
                      output logic [23:0] rd);
    logic [23:0] sh;
    sh = {hdr, dat};
    rd = '0;
    @(posedge clk) csn <= 1'h0;
    repeat (3) @(posedge clk);
    for (int i = 23; i >= 24 - nbits; i--) begin
      mosi <= sh[i];
      repeat (3) @(posedge clk);
      rd[i] = miso;
      sclk <= 1'h1;
      repeat (3) @(posedge clk);
      sclk <= 1'h0;
    end
    repeat (3) @(posedge clk);
    csn <= 1'h1;
    // Released line must not keep showing the last bit
    mosi <= ~mosi;
    @(posedge clk);
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import cfg_pkg::*;
  logic        clk, srst, sleep, csn, sclk, mosi, miso, miso_oe;
  logic [63:0] sig_src;
  logic [6:0]  tx_fill, rx_fill;
  logic        out_pin_a, out_pin_a_oe, out_pin_b, out_pin_b_oe, out_pin_c, out_pin_c_oe;
  logic        pins_drive_strength, temp_sensor_enable, trim_load;
  logic        tx_limit_reached, rx_limit_reached;
  logic [1:0]  rx_attenuation;
  logic [7:0]  analog_trim_one, analog_trim_two;
  logic [23:0] rd;
  logic [7:0]  rst_val [4] = '{8'h29, 8'h2E, 8'h3F, 8'h07};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  pin_select_fifo_threshold_regs #(.FILL_W(7)) dut (
    .clk, .srst, .csn, .sclk, .mosi, .miso, .miso_oe, .sleep, .sig_src, .tx_fill, .rx_fill,
    .out_pin_a, .out_pin_a_oe, .out_pin_b, .out_pin_b_oe, .out_pin_c, .out_pin_c_oe,
    .pins_drive_strength, .temp_sensor_enable, .rx_attenuation, .analog_trim_one,
    .analog_trim_two, .trim_load, .tx_limit_reached, .rx_limit_reached
  );
  spi_host host (.clk, .miso, .csn, .sclk, .mosi);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer({2'h0, a}, {d, 8'h00}, 16, rd);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    host.xfer({2'h2, a}, 16'h0000, 16, rd);
    chk($sformatf("reg %h", a), exp, rd[15:8]);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic lim(input int tx, input int rx, input logic et, input logic er);
    @(posedge clk);
    tx_fill <= 7'(tx);
    rx_fill <= 7'(rx);
    settle();
    chk("tx flag", {7'h00, et}, {7'h00, tx_limit_reached});
    chk("rx flag", {7'h00, er}, {7'h00, rx_limit_reached});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    srst = 1'h1;
    sleep = 1'h0;
    sig_src = '0;
    tx_fill = '0;
    rx_fill = '0;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    foreach (rst_val[i]) rdc(6'(i), rst_val[i]);
    chk("pin b oe", 8'h00, {7'h00, out_pin_b_oe});
    chk("pin c oe", 8'h01, {7'h00, out_pin_c_oe});
    chk("status", 8'h00, rd[23:16]);
    $display("reset values done");
    wr(ADDR_PIN_A, 8'h2E);
    settle();
    chk("pin a oe", 8'h00, {7'h00, out_pin_a_oe});
    wr(ADDR_PIN_C, 8'hC5);
    rdc(ADDR_PIN_C, 8'h45);
    chk("pin c", 8'h01, {7'h00, out_pin_c});
    @(posedge clk);
    sig_src <= 64'h20;
    settle();
    chk("pin c", 8'h00, {7'h00, out_pin_c});
    wr(ADDR_PIN_B, 8'hAE);
    rdc(ADDR_PIN_B, 8'hAE);
    chk("drive", 8'h01, {7'h00, pins_drive_strength});
    wr(ADDR_PIN_A, 8'h80);
    settle();
    chk("sensor", 8'h01, {7'h00, temp_sensor_enable});
    wr(ADDR_PIN_A, 8'h05);
    settle();
    chk("pin a", 8'h01, {7'h00, out_pin_a});
    chk("pin a oe", 8'h01, {7'h00, out_pin_a_oe});
    chk("sensor", 8'h00, {7'h00, temp_sensor_enable});
    $display("pin config done");
    // Each setting: at both limits and one byte below each
    for (int n = 0; n < 16; n++) begin
      wr(ADDR_THR, 8'h30 | 8'(n));
      lim(61 - 4 * n, 4 * n + 3, 1'h1, 1'h0);
      lim(60 - 4 * n, 4 * n + 4, 1'h0, 1'h1);
    end
    chk("atten", 8'h03, {6'h00, rx_attenuation});
    $display("thresholds done");
    wr(ADDR_THR, 8'h47);
    @(posedge clk);
    sleep <= 1'h1;
    wr(ADDR_PIN_B, 8'h00);
    rdc(ADDR_PIN_B, 8'hAE);
    chk("status", 8'h80, rd[23:16]);
    @(posedge clk);
    sleep <= 1'h0;
    settle();
    chk("trim one", 8'h35, analog_trim_one);
    chk("trim two", 8'h81, analog_trim_two);
    rdc(ADDR_TRIM_ONE, 8'h31);
    rdc(ADDR_TRIM_TWO, 8'h88);
    rdc(6'h10, 8'h00);
    host.xfer({2'h1, ADDR_PIN_B}, {8'h55, 8'h4A}, 24, rd);
    rdc(ADDR_PIN_B, 8'h55);
    rdc(ADDR_PIN_A, 8'h4A);
    host.xfer({2'h3, ADDR_PIN_B}, 16'h0000, 24, rd);
    chk("burst read b", 8'h55, rd[15:8]);
    chk("burst read a", 8'h4A, rd[7:0]);
    $display("sleep and wake done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
